// ==== core/pdm_core.sv ====
// pre-driver mode sequencer and serial command decoder, top level
// Behaviour
// - reset low keeps the block asleep with gates off under weak pull-down
// - sleep clears fault and serial state and sets all mask bits; logic outputs low except gate hold-off and mode_state, which reads sleep
// - reset high with an enable low gives standby, all gates actively off
// - in standby the serial port works; data out driven only while select low
// - reset and both enables high give initialization, low sides follow inputs
// - after initialization gates follow inputs while enables and reset stay high
// - a high side stays off until its low side has been pulsed
// - protective faults enter fault mode; recovery passes through initialization
// - fault mode turns all drivers actively off, whatever the fault mode setting
// - open inputs default to the states that leave the drivers off
// - the command is the last eight bits of a frame
// - top three bits are the opcode, low five bits the data
// - frames not a multiple of eight bits flag framing error and are dropped
// - first response after reset is status word zero
// - read command returns the selected status word and changes nothing
// - mask commands load the low nibble into group a or b enables
// - interrupt stays up after mask update while unmasked faults remain
// - mode command sets fault mode, full-on mode and lock bit
// - clear commands clear latched faults of group a or b per nibble bit
// - interrupt stays up after a clear while other unmasked faults remain
// - dead-time command programs the dead-time value and returns status zero
// - mask, mode, clear and dead-time commands return status word zero
// - clears act at select rise, only for valid frames and unchanged faults
// - lock is cleared only by reset; locked writes raise write error
// - read sub-select 00 gives status zero, 01 to 11 other internal words
// - group a enables ot, desat, uv, oc; group b phase, frame, write, reset
`timescale 1ns/1ps
module pdm_core (
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  input  wire logic                     enable_input_first,
  input  wire logic                     enable_input_second,
  input  wire logic [pdm_pkg::PHASES-1:0] low_side_phase_input,
  input  wire logic [pdm_pkg::PHASES-1:0] high_side_phase_input_n,
  input  wire logic                     sclk,
  input  wire logic                     si,
  input  wire logic                     chip_select_n,
  input  wire logic                     fault_overtemp,
  input  wire logic                     fault_desat,
  input  wire logic                     fault_phase,
  input  wire logic                     gate_drive_supply_undervoltage,
  input  wire logic                     fault_overcurrent,
  output logic      [pdm_pkg::PHASES-1:0] low_side_gate,
  output logic      [pdm_pkg::PHASES-1:0] high_side_gate,
  output logic                          gate_hold_off,
  output logic                          gate_active_off,
  output logic                          interrupt_out,
  output logic                          serial_out,
  output logic                          serial_out_oe,
  output logic      [pdm_pkg::DATA_MSB:0] dead_time_code,
  output logic                          fullon_mode,
  output pdm_pkg::pdm_mode_t            mode_state
);
  import pdm_pkg::*;

  // places a nibble into group a (low) or group b (high) of an eight-bit word
  function automatic logic [7:0] grp_place(input logic grp, input logic [3:0] nib);
    grp_place = grp ? {nib, NIB_NONE} : {NIB_NONE, nib};
  endfunction

  // ================================
  // pin synchronisers
  logic [PIN_W-1:0] pin_s;

  pdm_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_pin_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .d       ({enable_input_first, enable_input_second, low_side_phase_input,
               high_side_phase_input_n, fault_overtemp, fault_desat,
               gate_drive_supply_undervoltage, fault_overcurrent, fault_phase}),
    .q       (pin_s)
  );

  wire              en_both = pin_s[12] & pin_s[11];
  wire [PHASES-1:0] ls_s    = pin_s[10:8];
  wire [PHASES-1:0] hs_on   = ~pin_s[7:5];
  wire              ot_s    = pin_s[4];
  wire              desat_s = pin_s[3];
  wire              uv_s    = pin_s[2];
  wire              oc_s    = pin_s[1];
  wire              phase_s = pin_s[0];

  // ================================
  // serial shifter
  pdm_spi_if spi ();

  pdm_spi_shift u_spi (
    .sys_clk       (sys_clk),
    .nrst          (nrst),
    .sclk          (sclk),
    .si            (si),
    .chip_select_n (chip_select_n),
    .bus           (spi.shifter)
  );

  // ================================
  // registers
  pdm_mode_t        state_reg;
  pdm_mode_t        state_next;
  logic [PHASES-1:0] ls_prev_reg;
  logic [PHASES-1:0] hs_prev_reg;
  logic             ls_seen_reg;
  logic [PHASES-1:0] boot_ok_reg;
  logic [PHASES-1:0] ls_gate_reg;
  logic [PHASES-1:0] hs_gate_reg;
  logic             hold_off_reg;
  logic             active_off_reg;
  logic [7:0]       latch_reg;
  logic [7:0]       snap_reg;
  logic [7:0]       mask_reg;
  logic             desat_mode_reg;
  logic             fullon_reg;
  logic             lock_reg;
  logic [DATA_MSB:0] dead_reg;
  logic [SEL_MSB:0] resp_sel_reg;
  logic             int_reg;

  // ================================
  // command decode
  wire [2:0]        opc   = spi.rx_byte[OPC_MSB:OPC_LSB];
  wire              grp   = spi.rx_byte[GRP_BIT];
  wire [3:0]        nib   = spi.rx_byte[NIB_MSB:0];
  wire              valid = spi.frame_done & ~spi.frame_err;
  wire              is_null = valid & (opc == OP_NULL);
  wire              is_mask = valid & (opc == OP_MASK);
  wire              is_mode = valid & (opc == OP_MODE);
  wire              is_clr  = valid & (opc == OP_CLR);
  wire              is_dead = valid & (opc == OP_DEAD);
  wire              cfg_wr  = is_mask | is_mode | is_dead;
  wire              wr_ok   = ~lock_reg;
  wire              werr_ev = cfg_wr & lock_reg;
  wire              frame_ev = spi.frame_done & spi.frame_err;

  // ================================
  // mode sequencing
  wire in_drive   = (state_reg == PDM_INIT) | (state_reg == PDM_ENABLE);
  // desat and phase errors shut the stage down only while fault mode bit is clear
  wire prot_fault = uv_s | (~desat_mode_reg & (desat_s | phase_s));
  wire ls_toggle  = |(ls_s ^ ls_prev_reg);
  wire hs_toggle  = |(hs_on ^ hs_prev_reg);
  wire [PHASES-1:0] ls_pulse = ls_prev_reg & ~ls_s;
  wire rst_ev     = (state_reg == PDM_SLEEP) | ((state_reg != PDM_STANDBY) & ~en_both);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PDM_SLEEP: begin
        state_next = PDM_STANDBY;
      end
      PDM_STANDBY: begin
        if (en_both) begin
          state_next = PDM_INIT;
        end
      end
      PDM_INIT: begin
        if (!en_both) begin
          state_next = PDM_STANDBY;
        end else if (prot_fault) begin
          state_next = PDM_FAULT;
        end else if (ls_seen_reg && hs_toggle) begin
          state_next = PDM_ENABLE;
        end
      end
      PDM_ENABLE: begin
        if (!en_both) begin
          state_next = PDM_STANDBY;
        end else if (prot_fault) begin
          state_next = PDM_FAULT;
        end
      end
      PDM_FAULT: begin
        if (!en_both) begin
          state_next = PDM_STANDBY;
        end else if (!prot_fault) begin
          state_next = PDM_INIT;
        end
      end
      default: begin
        state_next = PDM_SLEEP;
      end
    endcase
  end

  // ================================
  // gate commands
  wire [PHASES-1:0] ls_next = in_drive ? ls_s : '0;
  // without full-on a phase never has both sides on at once
  wire [PHASES-1:0] hs_lock = fullon_reg ? '1 : ~ls_s;
  wire [PHASES-1:0] hs_next = (state_reg == PDM_ENABLE) ? (hs_on & boot_ok_reg & hs_lock) : '0;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg      <= PDM_SLEEP;
      ls_prev_reg    <= '0;
      hs_prev_reg    <= '0;
      ls_seen_reg    <= 1'b0;
      boot_ok_reg    <= '0;
      ls_gate_reg    <= '0;
      hs_gate_reg    <= '0;
      hold_off_reg   <= 1'b1;
      active_off_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      ls_prev_reg    <= ls_s;
      hs_prev_reg    <= hs_on;
      ls_seen_reg    <= (state_reg == PDM_INIT) & (ls_seen_reg | ls_toggle);
      boot_ok_reg    <= in_drive ? (boot_ok_reg | ls_pulse) : '0;
      ls_gate_reg    <= ls_next;
      hs_gate_reg    <= hs_next;
      hold_off_reg   <= (state_reg == PDM_SLEEP);
      active_off_reg <= (state_reg == PDM_STANDBY) | (state_reg == PDM_FAULT);
    end
  end

  // ================================
  // fault latches, masks and configuration
  wire [7:0] set_vec = {rst_ev, werr_ev, frame_ev, phase_s, oc_s, uv_s, desat_s, ot_s};
  // only bits seen set at select fall can be cleared, so a mid-frame fault survives
  wire [7:0] clr_vec = is_clr ? (grp_place(grp, nib) & snap_reg) : 8'h00;
  wire [7:0] mask_sel = grp_place(grp, NIB_ALL);
  wire [7:0] pend_vec = latch_reg & mask_reg;
  wire       pend     = |pend_vec;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      latch_reg      <= LATCH_RST;
      snap_reg       <= LATCH_RST;
      mask_reg       <= MASK_RST;
      desat_mode_reg <= 1'b0;
      fullon_reg     <= 1'b0;
      lock_reg       <= 1'b0;
      dead_reg       <= '0;
      resp_sel_reg   <= SEL_S0;
      int_reg        <= 1'b0;
    end else begin
      latch_reg <= (latch_reg & ~clr_vec) | set_vec;
      int_reg   <= pend;
      if (spi.cs_fall) begin
        snap_reg <= latch_reg;
      end
      if (is_mask && wr_ok) begin
        mask_reg <= (mask_reg & ~mask_sel) | grp_place(grp, nib);
      end
      if (is_mode && wr_ok) begin
        desat_mode_reg <= spi.rx_byte[M_DESAT];
        fullon_reg     <= spi.rx_byte[M_FULLON];
        lock_reg       <= spi.rx_byte[M_LOCK];
      end
      if (is_dead && wr_ok) begin
        dead_reg <= spi.rx_byte[DATA_MSB:0];
      end
      if (spi.frame_done) begin
        resp_sel_reg <= is_null ? spi.rx_byte[SEL_MSB:0] : SEL_S0;
      end
    end
  end

  // ================================
  // response word
  wire [7:0] word_mode = {1'b0, state_reg, desat_mode_reg, 1'b0, fullon_reg, lock_reg};
  wire [7:0] word_dead = {3'h0, dead_reg};

  assign spi.tx_byte = (resp_sel_reg == SEL_MASK) ? mask_reg :
                       (resp_sel_reg == SEL_MODE) ? word_mode :
                       (resp_sel_reg == SEL_DEAD) ? word_dead : latch_reg;

  assign low_side_gate   = ls_gate_reg;
  assign high_side_gate  = hs_gate_reg;
  assign gate_hold_off   = hold_off_reg;
  assign gate_active_off = active_off_reg;
  assign interrupt_out   = int_reg;
  assign serial_out      = spi.so_bit;
  assign serial_out_oe   = spi.so_oe;
  assign dead_time_code  = dead_reg;
  assign fullon_mode     = fullon_reg;
  assign mode_state      = state_reg;

  // ================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_standby_off;
    // the cycle leaving init or enable has not yet registered standby, so the window opens one cycle later
    (state_reg != PDM_SLEEP) && !en_both ##1 !en_both |=> (ls_gate_reg == '0) && (hs_gate_reg == '0) && active_off_reg;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("gates not off in standby");

  property p_init_ls_only;
    state_reg == PDM_INIT |=> (hs_gate_reg == '0) && (ls_gate_reg == $past(ls_s));
  endproperty
  a_init_ls_only: assert property (p_init_ls_only) else $error("init gate drive wrong");

  property p_boot_first;
    $rose(hs_gate_reg[0]) |-> $past(boot_ok_reg[0]) && $past(state_reg == PDM_ENABLE);
  endproperty
  a_boot_first: assert property (p_boot_first) else $error("high side on before boot charge");

  property p_fault_entry;
    (state_reg == PDM_ENABLE) && en_both && prot_fault |=> (state_reg == PDM_FAULT) ##1 (hs_gate_reg == '0);
  endproperty
  a_fault_entry: assert property (p_fault_entry) else $error("fault mode not entered");

  property p_fault_exit;
    (state_reg == PDM_FAULT) && en_both && !prot_fault |=> state_reg == PDM_INIT;
  endproperty
  a_fault_exit: assert property (p_fault_exit) else $error("fault recovery skipped init");

  property p_frame_flag;
    frame_ev |=> latch_reg[FLT_FRAME] && $stable(mask_reg) && $stable(dead_reg) && (resp_sel_reg == SEL_S0);
  endproperty
  a_frame_flag: assert property (p_frame_flag) else $error("framing error not handled");

  property p_null_quiet;
    is_null |=> $stable(mask_reg) && $stable(dead_reg) && $stable(lock_reg) && $stable(fullon_reg);
  endproperty
  a_null_quiet: assert property (p_null_quiet) else $error("read command changed state");

  property p_lock_werr;
    cfg_wr && lock_reg |=> latch_reg[FLT_WERR] && lock_reg && $stable(mask_reg) && $stable(dead_reg);
  endproperty
  a_lock_werr: assert property (p_lock_werr) else $error("locked write not refused");

  property p_int_level;
    pend ##1 pend |=> interrupt_out;
  endproperty
  a_int_level: assert property (p_int_level) else $error("interrupt dropped with faults pending");

  property p_clear;
    (clr_vec != 8'h00) && ((clr_vec & set_vec) == 8'h00) |=> (latch_reg & $past(clr_vec)) == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("fault clear did not act");
endmodule

// ==== core/pdm_pkg.sv ====
// shared constants, field positions and mode encoding for the pre-driver mode sequencer
package pdm_pkg;
  localparam int CMD_W  = 8;
  localparam int PHASES = 3;
  localparam int PIN_W  = 13;

  // command byte fields
  localparam int OPC_MSB  = 7;
  localparam int OPC_LSB  = 5;
  localparam int GRP_BIT  = 4;
  localparam int NIB_MSB  = 3;
  localparam int DATA_MSB = 4;
  localparam int SEL_MSB  = 1;
  localparam int M_DESAT  = 3;
  localparam int M_FULLON = 1;
  localparam int M_LOCK   = 0;

  localparam logic [2:0] OP_NULL = 3'h0;
  localparam logic [2:0] OP_MASK = 3'h1;
  localparam logic [2:0] OP_MODE = 3'h2;
  localparam logic [2:0] OP_CLR  = 3'h3;
  localparam logic [2:0] OP_DEAD = 3'h4;

  // status word 0 / fault latch bit positions
  localparam int FLT_OT    = 0;
  localparam int FLT_DESAT = 1;
  localparam int FLT_UV    = 2;
  localparam int FLT_OC    = 3;
  localparam int FLT_PHASE = 4;
  localparam int FLT_FRAME = 5;
  localparam int FLT_WERR  = 6;
  localparam int FLT_RST   = 7;

  localparam logic [7:0] MASK_RST  = 8'hff;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [3:0] NIB_ALL   = 4'hf;
  localparam logic [3:0] NIB_NONE  = 4'h0;

  // status word select
  localparam logic [1:0] SEL_S0   = 2'h0;
  localparam logic [1:0] SEL_MASK = 2'h1;
  localparam logic [1:0] SEL_MODE = 2'h2;
  localparam logic [1:0] SEL_DEAD = 2'h3;

  // pin synchroniser defaults: {en[1:0], ls[2:0], hs_n[2:0], ot, desat, uv, oc, phase}
  localparam logic [PIN_W-1:0] PIN_RST = 13'h00e0;
  localparam logic [2:0]       SPI_RST = 3'h4;

  typedef enum logic [2:0] {
    PDM_STANDBY = 3'h0,
    PDM_INIT    = 3'h1,
    PDM_ENABLE  = 3'h3,
    PDM_FAULT   = 3'h2,
    PDM_SLEEP   = 3'h4
  } pdm_mode_t;
endpackage

// ==== core/pdm_spi_if.sv ====
// link between the serial shifter and the command core
`timescale 1ns/1ps
interface pdm_spi_if;
  logic                     frame_done;
  logic                     frame_err;
  logic [pdm_pkg::CMD_W-1:0] rx_byte;
  logic                     cs_fall;
  logic [pdm_pkg::CMD_W-1:0] tx_byte;
  logic                     so_bit;
  logic                     so_oe;
  modport shifter (output frame_done, frame_err, rx_byte, cs_fall, so_bit, so_oe, input tx_byte);
  modport core    (input frame_done, frame_err, rx_byte, cs_fall, so_bit, so_oe, output tx_byte);
endinterface

// ==== core/pdm_spi_shift.sv ====
// serial slave: samples on rising clock, shifts out on falling clock, msb first
`timescale 1ns/1ps
module pdm_spi_shift (
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  input  wire logic   sclk,
  input  wire logic   si,
  input  wire logic   chip_select_n,
  pdm_spi_if.shifter  bus
);
  import pdm_pkg::*;

  logic [2:0]       pin_s;
  logic             sclk_prev_reg;
  logic             cs_prev_reg;
  logic [CMD_W-1:0] rx_reg;
  logic [CMD_W-1:0] tx_reg;
  logic [2:0]       cnt_reg;
  logic             any_reg;
  logic             done_reg;
  logic             err_reg;

  // unconnected chip select reads high, clock and data low
  pdm_sync #(.W(3), .RST_VAL(SPI_RST)) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .d       ({chip_select_n, sclk, si}),
    .q       (pin_s)
  );

  wire cs_n_s    = pin_s[2];
  wire sclk_s    = pin_s[1];
  wire si_s      = pin_s[0];
  wire sclk_rise = sclk_s & ~sclk_prev_reg & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_prev_reg & ~cs_n_s;
  wire cs_fall_w = cs_prev_reg & ~cs_n_s;
  wire cs_rise_w = ~cs_prev_reg & cs_n_s;

  // ================================
  // shift registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
      rx_reg        <= '0;
      tx_reg        <= '0;
      cnt_reg       <= 3'h0;
      any_reg       <= 1'b0;
      done_reg      <= 1'b0;
      err_reg       <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_prev_reg   <= cs_n_s;
      done_reg      <= cs_rise_w;
      // a count that is not a whole number of bytes, or an empty frame, is refused
      if (cs_rise_w) begin
        err_reg <= (cnt_reg != 3'h0) | ~any_reg;
      end
      if (cs_fall_w) begin
        tx_reg  <= bus.tx_byte;
        cnt_reg <= 3'h0;
        any_reg <= 1'b0;
      end else begin
        // only the last eight bits stay, earlier ones pass on down the chain
        if (sclk_rise) begin
          rx_reg  <= {rx_reg[CMD_W-2:0], si_s};
          cnt_reg <= cnt_reg + 3'h1;
          any_reg <= 1'b1;
        end
        if (sclk_fall) begin
          tx_reg <= {tx_reg[CMD_W-2:0], rx_reg[0]};
        end
      end
    end
  end

  assign bus.frame_done = done_reg;
  assign bus.frame_err  = err_reg;
  assign bus.rx_byte    = rx_reg;
  assign bus.cs_fall    = cs_fall_w;
  assign bus.so_bit     = tx_reg[CMD_W-1];
  assign bus.so_oe      = ~cs_prev_reg;
endmodule

// ==== core/pdm_sync.sv ====
// two-flop synchroniser with a per-bit reset level
`timescale 1ns/1ps
module pdm_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// ==== verification/pdm_host.sv ====
// serial master standing in for the microcontroller's serial port
`timescale 1ns/1ps
module pdm_host (
  input  wire logic sys_clk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  output logic      sclk,
  output logic      si,
  output logic      chip_select_n
);
  // output enable as seen at the last sampling edge of the most recent frame
  logic oe_seen;

  // serial clock stands still low between frames; data line rests at its pull-down level
  initial begin
    oe_seen = 1'b0;
    sclk = 1'b0;
    si = 1'b0;
    chip_select_n = 1'b1;
  end

  // ==========================================
  // one frame of n bits, msb first, 64 ns clock
  task automatic xfer(input int n, input logic [15:0] d, output logic [15:0] r);
    r = 16'h0000;
    @(posedge sys_clk) chip_select_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    for (int i = n - 1; i >= 0; i--) begin
      si <= d[i];
      repeat (8) @(posedge sys_clk);
      sclk <= 1'b1;
      r = {r[14:0], serial_out};
      oe_seen = serial_out_oe;
      repeat (8) @(posedge sys_clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    chip_select_n <= 1'b1;
    si <= 1'b0;
    // the core needs select high for a few synced cycles before the next frame
    repeat (24) @(posedge sys_clk);
  endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the pre-driver mode sequencer and command decoder
`timescale 1ns/1ps
module tb;
  import pdm_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        enable_input_first = 1'b0;
  logic        enable_input_second = 1'b0;
  logic [2:0]  low_side_phase_input = 3'h0;
  logic [2:0]  high_side_phase_input_n = 3'h7;
  logic        fault_overtemp = 1'b0;
  logic        fault_desat = 1'b0;
  logic        fault_phase = 1'b0;
  logic        gate_drive_supply_undervoltage = 1'b0;
  logic        fault_overcurrent = 1'b0;
  logic        sclk, si, chip_select_n;
  logic [2:0]  low_side_gate, high_side_gate;
  logic        gate_hold_off, gate_active_off, interrupt_out, serial_out, serial_out_oe, fullon_mode;
  logic [4:0]  dead_time_code;
  pdm_mode_t   mode_state;
  logic [15:0] rsp;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;

  always #2 sys_clk = ~sys_clk;

  pdm_core DUT (.sys_clk, .nrst, .enable_input_first, .enable_input_second, .low_side_phase_input,
    .high_side_phase_input_n, .sclk, .si, .chip_select_n, .fault_overtemp, .fault_desat, .fault_phase,
    .gate_drive_supply_undervoltage, .fault_overcurrent, .low_side_gate, .high_side_gate, .gate_hold_off,
    .gate_active_off, .interrupt_out, .serial_out, .serial_out_oe, .dead_time_code, .fullon_mode, .mode_state);
  pdm_host host (.sys_clk, .serial_out, .serial_out_oe, .sclk, .si, .chip_select_n);

  // ==========================================
  // shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic cmd(input int n, input logic [15:0] d);
    host.xfer(n, d, rsp);
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    wt(1);
    chk(8'(mode_state), 8'(PDM_SLEEP));
    chk({gate_hold_off, gate_active_off, interrupt_out, serial_out_oe, fullon_mode, low_side_gate}, 8'h80);
    chk({high_side_gate, dead_time_code}, 8'h00);
    @(posedge sys_clk) nrst <= 1'b1;
    wt(10);
    chk(8'(mode_state), 8'(PDM_STANDBY));
    chk({gate_hold_off, gate_active_off, interrupt_out, serial_out_oe}, 8'h06);
    cmd(8, 16'h0000);
    chk(rsp[7:0], 8'h80);
    chk(host.oe_seen, 1'b1);
  endtask
  task automatic t_read();
    logic [7:0] e [4];
    e = '{8'hff, 8'h00, 8'h00, 8'h80};
    cmd(8, 16'h0001);
    for (int i = 2; i < 6; i++) begin
      cmd(8, (i < 5) ? 16'(i % 4) : 16'h001c);
      chk(rsp[7:0], e[i - 2]);
    end
  endtask
  task automatic t_clear();
    cmd(8, 16'h0078);
    chk(rsp[7:0], 8'h80);
    wt(2);
    chk(interrupt_out, 1'b0);
    cmd(8, 16'h0000);
    chk(rsp[7:0], 8'h00);
  endtask
  task automatic t_mask();
    cmd(8, 16'h0020);
    @(posedge sys_clk) fault_overtemp <= 1'b1;
    wt(8);
    chk(interrupt_out, 1'b0);
    cmd(8, 16'h0021);
    chk(interrupt_out, 1'b1);
    cmd(8, 16'h0061);
    chk(interrupt_out, 1'b1);
    @(posedge sys_clk) fault_overtemp <= 1'b0;
    cmd(8, 16'h0061);
    chk(interrupt_out, 1'b0);
  endtask
  task automatic t_frame();
    cmd(7, 16'h0000);
    chk(interrupt_out, 1'b1);
    cmd(16, 16'ha595);
    chk(rsp[15:8], 8'h20);
    chk(rsp[7:0], 8'ha5);
    chk(dead_time_code, 8'h15);
    cmd(8, 16'h0072);
    chk(interrupt_out, 1'b0);
  endtask
  task automatic t_modes();
    @(posedge sys_clk) {enable_input_first, enable_input_second} <= 2'h3;
    wt(8);
    chk(8'(mode_state), 8'(PDM_INIT));
    @(posedge sys_clk) low_side_phase_input <= 3'h1;
    wt(8);
    chk(low_side_gate, 8'h01);
    @(posedge sys_clk) low_side_phase_input <= 3'h0;
    wt(8);
    @(posedge sys_clk) high_side_phase_input_n <= 3'h4;
    wt(8);
    chk(8'(mode_state), 8'(PDM_ENABLE));
    chk(high_side_gate, 8'h01);
    @(posedge sys_clk) gate_drive_supply_undervoltage <= 1'b1;
    wt(8);
    chk(8'(mode_state), 8'(PDM_FAULT));
    chk({high_side_gate, low_side_gate, gate_active_off}, 8'h01);
    @(posedge sys_clk) gate_drive_supply_undervoltage <= 1'b0;
    wt(8);
    chk(8'(mode_state), 8'(PDM_INIT));
    @(posedge sys_clk) enable_input_second <= 1'b0;
    high_side_phase_input_n <= 3'h7;
    wt(8);
    chk(8'(mode_state), 8'(PDM_STANDBY));
  endtask
  task automatic t_lock();
    cmd(8, 16'h004b);
    chk(fullon_mode, 1'b1);
    cmd(8, 16'h008a);
    chk(dead_time_code, 8'h15);
    cmd(8, 16'h0002);
    chk(rsp[7:0] & 8'h40, 8'h40);
    cmd(8, 16'h0000);
    chk(rsp[7:0], 8'h0b);
    @(posedge sys_clk) nrst <= 1'b0;
    wt(4);
    @(posedge sys_clk) nrst <= 1'b1;
    wt(10);
    chk(fullon_mode, 1'b0);
    cmd(8, 16'h008a);
    chk(dead_time_code, 8'h0a);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    t_reset();
    t_read();
    t_clear();
    t_mask();
    t_frame();
    t_modes();
    t_lock();
    end_of_test();
  end

  // a hang is cut short well beyond the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
endmodule
